/* core/pad_state_consts.svh */
// Constants for the pad-state controller
`ifndef PAD_STATE_CONSTS_SVH
`define PAD_STATE_CONSTS_SVH
`define PORT_WIDTH      8
`define P1_IN_ONLY_MASK 8'hC0
`define P4_WIDTH        6
`define P4_ABSENT_MASK  8'hC0
`define PIN_RESET_VAL   8'h00
`endif

/* core/pad_state_pkg.sv */
// Types for the pad-state controller
package pad_state_pkg;
    typedef enum logic [2:0] {
        MODE_RESET,
        MODE_SLEEP,
        MODE_STANDBY,
        MODE_WATCH,
        MODE_SUBACTIVE,
        MODE_ACTIVE
    } power_mode_t;
    typedef enum {
        ST_RESET,
        ST_RUN,
        ST_SLEEP,
        ST_LOWPOWER
    } pad_state_t;
endpackage

/* core/pad_ctrl_if.sv */
// Shared controls from the sequencer to every port slice
`timescale 1ns/1ps
interface pad_ctrl_if;
    logic run;
    logic hold;
    logic pullup_on;
    modport ctrl (output run, output hold, output pullup_on);
    modport port (input run, input hold, input pullup_on);
endinterface

/* core/pad_port_slice.sv */
// One 8-bit port: output, enable and pull-up per processing state
`timescale 1ns/1ps
`include "pad_state_consts.svh"
module pad_port_slice (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Controls
    pad_ctrl_if.port        ctl,
    input  wire logic [7:0] pullup_opt,
    input  wire logic [7:0] input_only,
    // Port registers
    input  wire logic [7:0] port_direction_register,
    input  wire logic [7:0] port_output_register,
    // Pad
    output logic      [7:0] pad_out,
    output logic      [7:0] pad_oe,
    output logic      [7:0] pad_pu
);
    logic [7:0] out_next;
    logic [7:0] oe_next;
    logic [7:0] pu_next;
    always_comb begin
        out_next = pad_out;
        oe_next  = pad_oe;
        pu_next  = ctl.pullup_on ? pullup_opt : 8'h00;
        if (ctl.run) begin
            out_next = port_output_register;
            oe_next  = port_direction_register & ~input_only;
        end else if (ctl.hold) begin
            // Outputs keep their last drive, inputs stay floating
            out_next = pad_out;
            oe_next  = pad_oe;
        end else begin
            out_next = `PIN_RESET_VAL;
            oe_next  = 8'h00;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pad_out <= `PIN_RESET_VAL;
            pad_oe  <= 8'h00;
            pad_pu  <= 8'h00;
        end else begin
            pad_out <= out_next;
            pad_oe  <= oe_next;
            pad_pu  <= pu_next;
        end
    end
    a_hold_keeps_out: assert property (@(posedge clk) disable iff (!arst_n)
        ctl.hold && !ctl.run |=> pad_out == $past(pad_out) && pad_oe == $past(pad_oe))
        else $error("held pad changed in sleep");
    a_float_lowpower: assert property (@(posedge clk) disable iff (!arst_n)
        !ctl.run && !ctl.hold |=> pad_oe == 8'h00)
        else $error("pad driven in low-power state");
    a_input_only_off: assert property (@(posedge clk) disable iff (!arst_n)
        ctl.run |=> (pad_oe & input_only) == 8'h00)
        else $error("input-only pin driven");
endmodule

/* core/pad_state_ctrl.sv */
// Pad-state controller for all general-purpose ports
// Behaviour
// - In sleep, output pins keep their last drive and input pins float.
// - After arst_n is released, pins with the pull-up option are pulled up in reset and sleep; in reset the others float.
// - Optioned pull-ups stay on in active and sleep whatever the port registers hold.
// - All optional pull-ups are off in standby, watch and subactive.
// - Peripheral input buffers stay on in low-power states; outside logic fixes their levels.
`timescale 1ns/1ps
`include "pad_state_consts.svh"
module pad_state_ctrl
    import pad_state_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Processing state from the system controller
    input  wire logic [2:0]  power_mode,
    // Fixed pull-up options, bit n of each byte per pin
    input  wire logic [7:0]  pullup_opt_p1,
    input  wire logic [7:0]  pullup_opt_p2,
    input  wire logic [7:0]  pullup_opt_p8,
    input  wire logic [7:0]  pullup_opt_p9,
    input  wire logic [7:0]  pullup_opt_pa,
    // Peripheral input select, one bit per pin of ports 1,2,8,9,A
    input  wire logic [39:0] periph_in_sel,
    // Port registers, ports 1,2,4,8,9,A packed low to high
    input  wire logic [47:0] port_direction_register,
    input  wire logic [47:0] port_output_register,
    // Pads in from the pins
    input  wire logic [7:0]  pad_in_p0,
    // Pads out, ports 1,2,4,8,9,A packed low to high
    output logic      [47:0] pad_out,
    output logic      [47:0] pad_oe,
    output logic      [47:0] pad_pu,
    output logic      [7:0]  pad_in_sync_p0,
    output logic      [39:0] input_buf_en
);
    pad_state_t  state_reg;
    pad_state_t  state_next;
    logic        run_reg;
    logic        hold_reg;
    logic        pu_reg;
    logic        run_next;
    logic        hold_next;
    logic        pu_next;
    logic [7:0]  p0_meta_reg;
    logic [7:0]  p0_meta_next;
    logic [7:0]  p0_sync_next;
    logic [39:0] ibuf_next;
    logic [7:0]  opt [6];
    logic [7:0]  inonly [6];
    pad_ctrl_if  ctl ();

    // Port 4 is open-drain and was built without any pull-up option
    assign opt[0] = pullup_opt_p1;
    assign opt[1] = pullup_opt_p2;
    assign opt[2] = 8'h00;
    assign opt[3] = pullup_opt_p8;
    assign opt[4] = pullup_opt_p9;
    assign opt[5] = pullup_opt_pa;
    // Port 1 pins 7:6 are inputs only; port 4 has no pins 7:6 at all
    assign inonly[0] = `P1_IN_ONLY_MASK;
    assign inonly[1] = 8'h00;
    assign inonly[2] = `P4_ABSENT_MASK;
    assign inonly[3] = 8'h00;
    assign inonly[4] = 8'h00;
    assign inonly[5] = 8'h00;

    always_comb begin
        // Undefined codes fall back to reset so no pin is ever driven by accident
        case (power_mode)
            MODE_RESET:     state_next = ST_RESET;
            MODE_SLEEP:     state_next = ST_SLEEP;
            MODE_ACTIVE:    state_next = ST_RUN;
            MODE_STANDBY,
            MODE_WATCH,
            MODE_SUBACTIVE: state_next = ST_LOWPOWER;
            default:        state_next = ST_RESET;
        endcase
        run_next  = (state_next == ST_RUN);
        hold_next = (state_next == ST_SLEEP);
        // Pull-ups follow the mode only, never the port registers
        pu_next = (state_next != ST_LOWPOWER);
        // Peripheral inputs stay buffered in every state
        ibuf_next = periph_in_sel;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg      <= ST_RESET;
            run_reg        <= 1'b0;
            hold_reg       <= 1'b0;
            pu_reg         <= 1'b1;
            input_buf_en   <= 40'h00_0000_0000;
        end else begin
            state_reg      <= state_next;
            run_reg        <= run_next;
            hold_reg       <= hold_next;
            pu_reg         <= pu_next;
            input_buf_en   <= ibuf_next;
        end
    end

    // Port 0 pins are asynchronous: two flops before anything reads them
    always_comb begin
        p0_meta_next = pad_in_p0;
        p0_sync_next = p0_meta_reg;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            p0_meta_reg    <= 8'h00;
            pad_in_sync_p0 <= 8'h00;
        end else begin
            p0_meta_reg    <= p0_meta_next;
            pad_in_sync_p0 <= p0_sync_next;
        end
    end

    assign ctl.run       = run_reg;
    assign ctl.hold      = hold_reg;
    assign ctl.pullup_on = pu_reg;

    // Every slice sees the same state controls; only options and masks differ
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_port
            pad_port_slice u_slice (
                .clk                     (clk),
                .arst_n                  (arst_n),
                .ctl                     (ctl.port),
                .pullup_opt              (opt[g]),
                .input_only              (inonly[g]),
                .port_direction_register (port_direction_register[g*8 +: 8]),
                .port_output_register    (port_output_register[g*8 +: 8]),
                .pad_out                 (pad_out[g*8 +: 8]),
                .pad_oe                  (pad_oe[g*8 +: 8]),
                .pad_pu                  (pad_pu[g*8 +: 8])
            );
        end
    endgenerate

    // Pad checks look one edge after state_reg, the latency of the port slices
    a_pu_off_lowpower: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_LOWPOWER |=> pad_pu == 48'h0)
        else $error("pull-up on in low-power state");

    a_pu_on_active: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_RUN |=> pad_pu[15:0] == $past({pullup_opt_p2, pullup_opt_p1}))
        else $error("optioned pull-up off in active");

    a_pu_on_sleep: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_SLEEP |=> pad_pu == $past({pullup_opt_pa, pullup_opt_p9,
        pullup_opt_p8, 8'h00, pullup_opt_p2, pullup_opt_p1}))
        else $error("optioned pull-up off in sleep");

    // The release edge still resets the flops, so the sampled reset gates these
    a_pu_in_reset: assert property (@(posedge clk) disable iff (!arst_n)
        arst_n && state_reg == ST_RESET |=> pad_pu[47:24] == $past({pullup_opt_pa,
        pullup_opt_p9, pullup_opt_p8}))
        else $error("reset pull-up wrong");

    a_reset_float: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_RESET |=> pad_oe == 48'h0)
        else $error("pad driven in reset");

    a_lowpower_float: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_LOWPOWER |=> pad_oe == 48'h0)
        else $error("pad driven in low-power state");

    a_lowpower_out: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_LOWPOWER |=> pad_out == 48'h0)
        else $error("pad output left set in low-power state");

    // Sleep freezes whatever the slices held one edge before
    a_sleep_holds: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_SLEEP && $past(state_reg) == ST_SLEEP
        |=> $stable(pad_oe) && $stable(pad_out))
        else $error("sleep pads changed");

    a_sleep_no_new_drive: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_SLEEP |=> (pad_oe & ~$past(pad_oe)) == 48'h0)
        else $error("input pin started driving in sleep");

    a_ibuf_kept: assert property (@(posedge clk) disable iff (!arst_n)
        arst_n |=> input_buf_en == $past(periph_in_sel))
        else $error("peripheral buffer dropped");

    a_p0_two_stage: assert property (@(posedge clk) disable iff (!arst_n)
        arst_n ##2 1'b1 |-> pad_in_sync_p0 == $past(pad_in_p0, 2))
        else $error("port 0 sync wrong");

    a_active_inputs: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_RUN |=> pad_oe[7:6] == 2'b00)
        else $error("input-only pin driven");

    a_run_drive: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_RUN |=> pad_oe == ($past(port_direction_register)
        & {24'hFF_FFFF, ~`P4_ABSENT_MASK, 8'hFF, ~`P1_IN_ONLY_MASK}))
        else $error("active pad enable does not follow direction");

    a_run_out: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_RUN |=> pad_out == $past(port_output_register))
        else $error("active pad output does not follow output register");

    a_mode_decode: assert property (@(posedge clk) disable iff (!arst_n)
        arst_n && power_mode == MODE_ACTIVE |=> state_reg == ST_RUN)
        else $error("active mode not decoded");

    // Main scenarios: sleep entry, any cycle in low power, wake, and exit from reset
    c_sleep: cover property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_RUN ##1 state_reg == ST_SLEEP);
    c_lowpower: cover property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_LOWPOWER);
    c_wake: cover property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_LOWPOWER ##1 state_reg == ST_RUN);
    c_sleep_to_lowpower: cover property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_SLEEP ##1 state_reg == ST_LOWPOWER);
    c_reset_to_run: cover property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_RESET ##1 state_reg == ST_RUN);
endmodule

/* verif/tb_port_pad_state_by_power_mode.sv */
// Self-checking bench for the pad-state controller
`timescale 1ns/1ps
module tb_port_pad_state_by_power_mode;
    import pad_state_pkg::*;
    logic        clk        = 1'b0;
    logic        arst_n     = 1'b0;
    logic [2:0]  power_mode = 3'h0;
    logic [47:0] opt        = 48'h0;
    logic [47:0] dir        = 48'h0;
    logic [47:0] outr       = 48'h0;
    logic [39:0] psel       = 40'h0;
    logic [7:0]  pin0       = 8'h0;
    logic [47:0] pad_out;
    logic [47:0] pad_oe;
    logic [47:0] pad_pu;
    logic [7:0]  sync0;
    logic [39:0] ibuf;
    logic [47:0] e_out;
    logic [47:0] e_oe;
    logic [63:0] r;
    int          err_count;
    int          cmp_count;
    int          cycles;
    // Port 1 pins 7:6 and the missing port 4 pins never drive
    localparam logic [47:0] IO_MASK = 48'h0000_00C0_00C0;

    pad_state_ctrl uut (
        .clk(clk), .arst_n(arst_n), .power_mode(power_mode),
        .pullup_opt_p1(opt[7:0]), .pullup_opt_p2(opt[15:8]), .pullup_opt_p8(opt[31:24]),
        .pullup_opt_p9(opt[39:32]), .pullup_opt_pa(opt[47:40]), .periph_in_sel(psel),
        .port_direction_register(dir), .port_output_register(outr), .pad_in_p0(pin0),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu),
        .pad_in_sync_p0(sync0), .input_buf_en(ibuf)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task complete_run();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Mode first, registers later, so a sleep entry freezes the settled values
    task automatic step(input logic [2:0] m);
        logic [47:0] x_out;
        logic [47:0] x_oe;
        logic [47:0] x_pu;
        @(posedge clk);
        power_mode <= m;
        repeat (3) @(posedge clk);
        r = {$urandom(), $urandom()};
        dir <= r[47:0];
        r = {$urandom(), $urandom()};
        outr <= r[47:0];
        psel <= r[63:24];
        pin0 <= r[7:0] ^ r[63:56];
        repeat (4) @(posedge clk);
        #1;
        x_pu = opt;
        case (m)
            MODE_SLEEP: begin
                x_out = e_out;
                x_oe  = e_oe;
            end
            MODE_STANDBY, MODE_WATCH, MODE_SUBACTIVE: begin
                x_out = 48'h0;
                x_oe  = 48'h0;
                x_pu  = 48'h0;
            end
            MODE_ACTIVE: begin
                x_out = outr;
                x_oe  = dir & ~IO_MASK;
            end
            default: begin
                x_out = 48'h0;
                x_oe  = 48'h0;
            end
        endcase
        check(pad_oe, x_oe);
        check(pad_out, x_out);
        check(pad_pu, x_pu);
        check({8'h0, ibuf}, {8'h0, psel});
        check({40'h0, sync0}, {40'h0, pin0});
        e_out = x_out;
        e_oe  = x_oe;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            complete_run();
        end
    end

    initial begin
        err_count = 0;
        cmp_count = 0;
        cycles    = 0;
        e_out     = 48'h0;
        e_oe      = 48'h0;
        r = {32'h0, $urandom(32'h0334C9C9)};
        @(posedge clk);
        // Port 4 byte is open-drain and has no pull-up option
        opt <= {r[31:0], 16'h0000} & 48'hFFFF_FF00_FFFF | {40'h0, r[7:0]};
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 40; i++) begin
                step(i < 8 ? 3'(i) : 3'($urandom_range(7)));
            end
            $display("mode sweep %0d done", p);
            @(posedge clk);
            opt <= 48'hFFFF_FF00_FFFF;
        end
        step(MODE_ACTIVE);
        @(posedge clk);
        arst_n <= 1'b0;
        power_mode <= MODE_RESET;
        repeat (2) @(posedge clk);
        #1;
        check(pad_oe | pad_out | pad_pu, 48'h0);
        @(posedge clk);
        arst_n <= 1'b1;
        e_out = 48'h0;
        e_oe  = 48'h0;
        step(MODE_RESET);
        step(MODE_SLEEP);
        $display("mid-run reset done");
        complete_run();
    end
endmodule
